/* verilog/dmc_config_regs.sv */
// Diagnostic, voltage monitor and shunt amplifier configuration registers
`timescale 1ns/1ps
`default_nettype none
module dmc_config_regs (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       resetn,
	// Register access from the serial interface
	input  wire dmc_pkg::dmc_req_t          req,
	input  wire logic                       req_valid,
	output logic [7:0]                      rdata,
	output logic                            rvalid,
	// Global diagnostic enable held elsewhere
	input  wire logic                       offline_diag_global_en,
	// Diagnostic current sources, bit 15 = bridge1 pull-up
	output logic [15:0]                     diag_source_en,
	// Monitor comparator levels from the analogue side, plus the fault clear
	input  wire logic                       supply_uv_cmp,
	input  wire logic                       supply_ov_cmp,
	input  wire logic                       pump_uv_cmp,
	input  wire logic                       fault_clear,
	// Monitor thresholds and results
	output logic                            supply_overvolt_threshold,
	output logic                            pump_undervolt_threshold,
	output logic                            supply_uv_fault,
	output logic                            supply_ov_fault,
	output logic                            supply_ov_warn,
	output logic                            pump_uv_fault,
	// Shunt amplifier settings
	output logic                            amp1_ref_divider,
	output logic [1:0]                      amp1_gain,
	output logic                            amp2_ref_divider,
	output logic [1:0]                      amp2_gain,
	// Blanking
	input  wire logic [7:0]                 bridge_switch,
	input  wire logic [15:0]                gate_drive_time,
	output logic                            amp1_blank
);
	typedef struct packed {
		logic [7:0]         diag_lo;
		logic [7:0]         diag_hi;
		dmc_pkg::dmc_vmon_t vmon;
		dmc_pkg::dmc_gain_t gain;
		dmc_pkg::dmc_blank_t blk;
		logic [7:0]         rdata;
		logic               rvalid;
		logic [15:0]        src;
		logic [2:0][2:0]    cmp_sync;
		logic [7:0]         sw_sync0;
		logic [7:0]         sw_sync1;
		logic [7:0]         sw_sync2;
		logic [7:0]         sw_stable;
		logic               sw_tog;
		logic [2:0]         cmp_stable;
		logic               glob_q;
		logic               uv_q;
		logic               ov_q;
		logic               ovw_q;
		logic               cp_q;
		logic               blank_q;
		logic               clr_q;
	} dmc_cr_state_t;

	dmc_cr_state_t s_q;
	dmc_cr_state_t s_d;

	logic                          uv_f;
	logic                          ov_f;
	logic                          cp_f;
	logic                          blank_w;
	logic [dmc_pkg::DG_CNT_W-1:0]  dg_cycles;
	logic                          ov_en;
	logic [2:0]                    cmp_ok;
	logic                          sw_sel;

	// Deglitch doubles per code step from the 1 us base
	always_comb begin
		dg_cycles = dmc_pkg::DG_CNT_W'(dmc_pkg::DG_BASE_CYC)
			<< s_q.vmon.supply_overvolt_deglitch;
		ov_en     = (s_q.vmon.supply_overvolt_response
			!= dmc_pkg::OV_DISABLE);
		// Filtered comparator levels and the trigger toggle
		cmp_ok = s_q.cmp_stable;
		sw_sel = s_q.sw_tog;
	end

	dmc_fault_mon u_supply_uv (
		.clk          (clk),
		.resetn       (resetn),
		.cond         (cmp_ok[0]),
		.enable       (1'b1),
		.auto_recover (s_q.vmon.supply_undervolt_response),
		.dg_cycles    (dmc_pkg::DG_CNT_W'(1)),
		.clear        (s_q.clr_q),
		.fault        (uv_f)
	);

	dmc_fault_mon u_supply_ov (
		.clk          (clk),
		.resetn       (resetn),
		.cond         (cmp_ok[1]),
		.enable       (ov_en),
		.auto_recover (s_q.vmon.supply_overvolt_response
			!= dmc_pkg::OV_LATCH),
		.dg_cycles    (dg_cycles),
		.clear        (s_q.clr_q),
		.fault        (ov_f)
	);

	dmc_fault_mon u_pump_uv (
		.clk          (clk),
		.resetn       (resetn),
		.cond         (cmp_ok[2]),
		.enable       (1'b1),
		.auto_recover (s_q.vmon.pump_undervolt_response),
		.dg_cycles    (dmc_pkg::DG_CNT_W'(1)),
		.clear        (s_q.clr_q),
		.fault        (cp_f)
	);

	dmc_blanker u_amp1_blank (
		.clk          (clk),
		.resetn       (resetn),
		.sw_level     (sw_sel),
		.duration     (s_q.blk.amp1_blank_duration),
		.drive_cycles (gate_drive_time),
		.blank        (blank_w)
	);

	always_comb begin
		s_d        = s_q;
		s_d.rvalid = 1'b0;
		s_d.clr_q  = fault_clear;
		// Three-stage sync of analogue comparator levels
		for (int i = 0; i < 3; i++)
			s_d.cmp_sync[i] = {s_q.cmp_sync[i][1:0], 1'b0};
		s_d.cmp_sync[0][0] = supply_uv_cmp;
		s_d.cmp_sync[1][0] = supply_ov_cmp;
		s_d.cmp_sync[2][0] = pump_uv_cmp;
		s_d.sw_sync0 = bridge_switch;
		s_d.sw_sync1 = s_q.sw_sync0;
		s_d.sw_sync2 = s_q.sw_sync1;
		// A level change counts once stages two and three agree
		for (int i = 0; i < 3; i++)
			if (s_q.cmp_sync[i][1] == s_q.cmp_sync[i][2])
				s_d.cmp_stable[i] = s_q.cmp_sync[i][2];
		for (int i = 0; i < 8; i++)
			if (s_q.sw_sync1[i] == s_q.sw_sync2[i])
				s_d.sw_stable[i] = s_q.sw_sync2[i];
		// Every bridge is filtered so that reselecting the trigger is not
		// taken as a switching event; only the chosen bridge flips the toggle
		if (s_d.sw_stable[s_q.blk.amp1_blank_trigger]
			!= s_q.sw_stable[s_q.blk.amp1_blank_trigger])
			s_d.sw_tog = ~s_q.sw_tog;

		if (req_valid && req.wr_en) begin
			case (req.addr)
			dmc_pkg::ADDR_DIAG_LO:  s_d.diag_lo = req.wdata;
			dmc_pkg::ADDR_DIAG_HI:  s_d.diag_hi = req.wdata;
			dmc_pkg::ADDR_VMON:     s_d.vmon = req.wdata;
			dmc_pkg::ADDR_AMP_GAIN:
				s_d.gain = req.wdata & dmc_pkg::MASK_AMP_GAIN;
			dmc_pkg::ADDR_AMP1_BLK:
				s_d.blk = req.wdata & dmc_pkg::MASK_AMP1_BLK;
			default: ;
			endcase
		end
		if (req_valid && !req.wr_en) begin
			s_d.rvalid = 1'b1;
			case (req.addr)
			dmc_pkg::ADDR_DIAG_LO:  s_d.rdata = s_q.diag_lo;
			dmc_pkg::ADDR_DIAG_HI:  s_d.rdata = s_q.diag_hi;
			dmc_pkg::ADDR_VMON:     s_d.rdata = s_q.vmon;
			dmc_pkg::ADDR_AMP_GAIN: s_d.rdata = s_q.gain;
			dmc_pkg::ADDR_AMP1_BLK: s_d.rdata = s_q.blk;
			default:                s_d.rdata = 8'h00;
			endcase
		end

		// Sources follow the registers only under the global enable
		s_d.glob_q = offline_diag_global_en;
		s_d.src    = s_q.glob_q ? {s_q.diag_lo, s_q.diag_hi} : 16'h0000;
		s_d.uv_q   = uv_f;
		// Warning mode reports without acting as a fault
		s_d.ov_q   = ov_f && (s_q.vmon.supply_overvolt_response
			!= dmc_pkg::OV_WARN);
		s_d.ovw_q  = ov_f && (s_q.vmon.supply_overvolt_response
			== dmc_pkg::OV_WARN);
		s_d.cp_q   = cp_f;
		s_d.blank_q = blank_w;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q         <= '0;
			s_q.diag_lo <= dmc_pkg::RST_DIAG_LO;
			s_q.diag_hi <= dmc_pkg::RST_DIAG_HI;
			s_q.vmon    <= dmc_pkg::RST_VMON;
			s_q.gain    <= dmc_pkg::RST_AMP_GAIN;
			s_q.blk     <= dmc_pkg::RST_AMP1_BLK;
		end else begin
			s_q <= s_d;
		end
	end

	// Register fields feed the analogue trims directly
	assign rdata                     = s_q.rdata;
	assign rvalid                    = s_q.rvalid;
	assign diag_source_en            = s_q.src;
	assign supply_overvolt_threshold = s_q.vmon.supply_overvolt_threshold;
	assign pump_undervolt_threshold  = s_q.vmon.pump_undervolt_threshold;
	assign supply_uv_fault           = s_q.uv_q;
	assign supply_ov_fault           = s_q.ov_q;
	assign supply_ov_warn            = s_q.ovw_q;
	assign pump_uv_fault             = s_q.cp_q;
	assign amp1_ref_divider          = s_q.gain.amp1_ref_divider;
	assign amp1_gain                 = s_q.gain.amp1_gain;
	assign amp2_ref_divider          = s_q.gain.amp2_ref_divider;
	assign amp2_gain                 = s_q.gain.amp2_gain;
	assign amp1_blank                = s_q.blank_q;
endmodule
`default_nettype wire

/* verilog/dmc_pkg.sv */
// Package: register map, field layouts, reset values and timing for the block
package dmc_pkg;

	// Register bus word and address widths
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 6;

	// Register offsets
	localparam logic [5:0] ADDR_DIAG_LO  = 6'h23;
	localparam logic [5:0] ADDR_DIAG_HI  = 6'h24;
	localparam logic [5:0] ADDR_VMON     = 6'h25;
	localparam logic [5:0] ADDR_AMP_GAIN = 6'h26;
	localparam logic [5:0] ADDR_AMP1_BLK = 6'h27;

	// Reset values
	localparam logic [7:0] RST_DIAG_LO  = 8'h00;
	localparam logic [7:0] RST_DIAG_HI  = 8'h00;
	localparam logic [7:0] RST_VMON     = 8'h14;
	localparam logic [7:0] RST_AMP_GAIN = 8'h09;
	localparam logic [7:0] RST_AMP1_BLK = 8'h00;

	// Writable bits; reserved bits stay zero
	localparam logic [7:0] MASK_AMP_GAIN = 8'h3f;
	localparam logic [7:0] MASK_AMP1_BLK = 8'h3f;

	// Voltage monitor configuration layout
	typedef struct packed {
		logic       supply_undervolt_response;
		logic [1:0] supply_overvolt_response;
		logic [1:0] supply_overvolt_deglitch;
		logic       supply_overvolt_threshold;
		logic       pump_undervolt_response;
		logic       pump_undervolt_threshold;
	} dmc_vmon_t;

	// Amplifier gain and reference layout
	typedef struct packed {
		logic [1:0] reserved;
		logic       amp1_ref_divider;
		logic [1:0] amp1_gain;
		logic       amp2_ref_divider;
		logic [1:0] amp2_gain;
	} dmc_gain_t;

	// Amplifier 1 blanking layout
	typedef struct packed {
		logic [1:0] reserved;
		logic [2:0] amp1_blank_trigger;
		logic [2:0] amp1_blank_duration;
	} dmc_blank_t;

	// Register bus request carrier
	typedef struct packed {
		logic             wr_en;
		logic [5:0]       addr;
		logic [7:0]       wdata;
	} dmc_req_t;

	// Overvoltage response codes
	localparam logic [1:0] OV_LATCH   = 2'h0;
	localparam logic [1:0] OV_AUTO    = 2'h1;
	localparam logic [1:0] OV_WARN    = 2'h2;
	localparam logic [1:0] OV_DISABLE = 2'h3;

	// Single-bit response codes
	localparam logic MODE_LATCH = 1'h0;

	// Clock and deglitch timing
	localparam int unsigned CLK_NS      = 100;
	localparam int unsigned DG_BASE_NS  = 1000;
	localparam int unsigned DG_BASE_CYC = (DG_BASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned DG_CNT_W    = 8;

	// Blanking: duration is (code+1)/8 of the gate drive time, code 0 is off, one code step = 12.5 %
	localparam int unsigned BLK_FRAC_W  = 3;
	localparam int unsigned BLK_CNT_W   = 16;
	localparam logic [2:0]  BLK_OFF     = 3'h0;
	localparam logic [3:0]  BLK_BIAS    = 4'h1;

endpackage

/* verilog/dmc_fault_mon.sv */
// Fault monitor: deglitch filter plus latched or auto-recovery fault flag
`timescale 1ns/1ps
`default_nettype none
module dmc_fault_mon (
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           resetn,
	// Condition and configuration
	input  wire logic                           cond,
	input  wire logic                           enable,
	input  wire logic                           auto_recover,
	input  wire logic [dmc_pkg::DG_CNT_W-1:0]   dg_cycles,
	input  wire logic                           clear,
	// Result
	output logic                                fault
);
	typedef struct packed {
		logic [dmc_pkg::DG_CNT_W-1:0] cnt;
		logic                         flag;
	} dmc_fm_state_t;

	dmc_fm_state_t s_q;
	dmc_fm_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (!enable) begin
			s_d.cnt  = '0;
			s_d.flag = 1'b0;
		end else begin
			// A short excursion restarts the count
			if (!cond)
				s_d.cnt = '0;
			else if (s_q.cnt < dg_cycles)
				s_d.cnt = s_q.cnt + 1'b1;
			if (auto_recover) begin
				s_d.flag = cond && (s_q.cnt >= dg_cycles);
			end else begin
				// Set wins over a simultaneous clear
				if (clear)
					s_d.flag = 1'b0;
				if (cond && s_q.cnt >= dg_cycles)
					s_d.flag = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign fault = s_q.flag;
endmodule
`default_nettype wire

/* verilog/dmc_blanker.sv */
// Amplifier blanking timer started by switching edges of one half-bridge
`timescale 1ns/1ps
`default_nettype none
module dmc_blanker (
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            resetn,
	// Trigger and configuration
	input  wire logic                            sw_level,
	input  wire logic [2:0]                      duration,
	input  wire logic [dmc_pkg::BLK_CNT_W-1:0]   drive_cycles,
	// Result
	output logic                                 blank
);
	typedef struct packed {
		logic                          last;
		logic [dmc_pkg::BLK_CNT_W-1:0] cnt;
	} dmc_bk_state_t;

	dmc_bk_state_t s_q;
	dmc_bk_state_t s_d;
	logic [dmc_pkg::BLK_CNT_W+3:0] prod;
	logic [dmc_pkg::BLK_CNT_W-1:0] span;

	// Code n covers (n+1)/8 of the drive time
	always_comb begin
		prod = drive_cycles * ({1'b0, duration} + dmc_pkg::BLK_BIAS);
		span = prod[dmc_pkg::BLK_CNT_W+2:dmc_pkg::BLK_FRAC_W];
	end

	always_comb begin
		s_d      = s_q;
		s_d.last = sw_level;
		if (duration == dmc_pkg::BLK_OFF)
			s_d.cnt = '0;
		else if (sw_level != s_q.last)
			s_d.cnt = span;
		else if (s_q.cnt != '0)
			s_d.cnt = s_q.cnt - 1'b1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign blank = (s_q.cnt != '0);
endmodule
`default_nettype wire

/* dv/dmc_config_regs_chk.sv */
// Checker: timing and value relations at the register bank ports
`timescale 1ns/1ps
`default_nettype none
module dmc_config_regs_chk (
	// Clock and reset
	input wire logic              clk,
	input wire logic              resetn,
	// Register access
	input wire dmc_pkg::dmc_req_t req,
	input wire logic              req_valid,
	input wire logic [7:0]        rdata,
	input wire logic              rvalid,
	// Watched outputs and inputs
	input wire logic              offline_diag_global_en,
	input wire logic [15:0]       diag_source_en,
	input wire logic              supply_ov_cmp,
	input wire logic              fault_clear,
	input wire logic              supply_overvolt_threshold,
	input wire logic              pump_undervolt_threshold,
	input wire logic              supply_ov_fault,
	input wire logic              pump_uv_fault,
	input wire logic              amp1_ref_divider,
	input wire logic [1:0]        amp1_gain,
	input wire logic              amp2_ref_divider,
	input wire logic [1:0]        amp2_gain,
	input wire logic              amp1_blank
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Shadow of the mode and duration fields, mode is not visible at ports
	logic [7:0] vmon_q;
	logic [2:0] dur_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vmon_q <= dmc_pkg::RST_VMON;
			dur_q  <= 3'h0;
		end else if (req_valid && req.wr_en) begin
			if (req.addr == dmc_pkg::ADDR_VMON)
				vmon_q <= req.wdata;
			if (req.addr == dmc_pkg::ADDR_AMP1_BLK)
				dur_q <= req.wdata[2:0];
		end
	end

	sequence s_read(logic [5:0] a);
		req_valid && !req.wr_en && req.addr == a;
	endsequence
	sequence s_pump_held;
		(pump_uv_fault && !vmon_q[1] && !fault_clear) [*3];
	endsequence

	AST_RD_ANSWER: assert property (req_valid && !req.wr_en |=> rvalid)
		else $error("read not answered next cycle");
	AST_NO_STRAY_RVALID: assert property (rvalid |-> $past(req_valid && !req.wr_en))
		else $error("rvalid without a read");
	AST_VMON_RD: assert property (s_read(dmc_pkg::ADDR_VMON) |=>
		rdata[2] == supply_overvolt_threshold && rdata[0] == pump_undervolt_threshold)
		else $error("threshold outputs differ from register");
	AST_GAIN_RD: assert property (s_read(dmc_pkg::ADDR_AMP_GAIN) |=>
		rdata == {2'h0, amp1_ref_divider, amp1_gain, amp2_ref_divider, amp2_gain})
		else $error("gain outputs differ from register");
	AST_BLK_RSVD: assert property (s_read(dmc_pkg::ADDR_AMP1_BLK) |=> rdata[7:6] == 2'h0)
		else $error("reserved blanking bits not zero");
	AST_DIAG_GATE: assert property (!offline_diag_global_en [*3] |-> diag_source_en == 16'h0)
		else $error("diag source on without global enable");
	AST_OV_DEGLITCH: assert property ($rose(supply_ov_fault) |-> $past(supply_ov_cmp, 8))
		else $error("overvoltage fault without persistent condition");
	AST_PUMP_LATCH: assert property (s_pump_held |=> pump_uv_fault)
		else $error("latched pump fault dropped without clear");
	AST_BLANK_OFF: assert property ($rose(amp1_blank) |-> dur_q != 3'h0)
		else $error("blanking while disabled");
endmodule
`default_nettype wire

/* dv/dmc_host_model.sv */
// Host model: single-byte register requests on the strobe port
`timescale 1ns/1ps
`default_nettype none
module dmc_host_model (
	// Clock
	input  wire logic             clk,
	// Register access
	output var dmc_pkg::dmc_req_t req,
	output logic                  req_valid,
	input  wire logic [7:0]       rdata,
	input  wire logic             rvalid
);
	initial begin
		req = '{wr_en: 1'b0, addr: 6'h3f, wdata: 8'h5a};
		req_valid = 1'b0;
	end
	// One access; a read waits a bounded time for its answer
	task automatic xfer(input logic wr, input logic [5:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		@(posedge clk);
		#1;
		req = '{wr_en: wr, addr: a, wdata: d};
		req_valid = 1'b1;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		// Released bus carries no stale value
		req = ~req;
		q = 8'hxx;
		n = 0;
		while (!wr && rvalid !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (!wr && rvalid === 1'b1)
			q = rdata;
	endtask
endmodule
`default_nettype wire

/* dv/tb_dmc_config_regs.sv */
// Testbench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_dmc_config_regs;
	typedef struct packed {
		logic [5:0] a;
		logic [7:0] rst;
		logic [7:0] wd;
		logic [7:0] exp;
	} dmc_tb_row_t;
	logic              clk, resetn, gen, suv, sov, puv, clr, req_valid, rvalid;
	dmc_pkg::dmc_req_t req;
	logic [7:0]        rdata, q, sw;
	logic [15:0]       diag, gdt;
	logic              thr_ov, thr_p, uvf, ovf, ovw, pf, a1d, a2d, blank;
	logic [1:0]        a1g, a2g;
	int                checks, miscompares, c, d;
	dmc_tb_row_t       rows [6];

	dmc_host_model u_dmc_host_model (.clk, .req, .req_valid, .rdata, .rvalid);
	dmc_config_regs u_dmc_config_regs (.clk, .resetn, .req, .req_valid,
		.rdata, .rvalid, .offline_diag_global_en(gen), .diag_source_en(diag),
		.supply_uv_cmp(suv), .supply_ov_cmp(sov), .pump_uv_cmp(puv),
		.fault_clear(clr), .supply_overvolt_threshold(thr_ov),
		.pump_undervolt_threshold(thr_p), .supply_uv_fault(uvf),
		.supply_ov_fault(ovf), .supply_ov_warn(ovw), .pump_uv_fault(pf),
		.amp1_ref_divider(a1d), .amp1_gain(a1g), .amp2_ref_divider(a2d),
		.amp2_gain(a2g), .bridge_switch(sw), .gate_drive_time(gdt),
		.amp1_blank(blank));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			$display("Error %0t: %s got %h expected %h", $time, what, got, exp);
			miscompares++;
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse_clear();
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		cyc(8);
	endtask
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#(20000 * 100);
		miscompares++;
		conclude();
	end

	initial begin
		{resetn, suv, sov, puv, clr, sw} = '0;
		gen = 1'b1;
		gdt = 16'd16;
		checks = 0;
		miscompares = 0;
		rows = '{'{dmc_pkg::ADDR_DIAG_LO, 8'h00, 8'h93, 8'h93},
			'{dmc_pkg::ADDR_DIAG_HI, 8'h00, 8'ha5, 8'ha5},
			'{dmc_pkg::ADDR_VMON, 8'h14, 8'h6b, 8'h6b},
			'{dmc_pkg::ADDR_AMP_GAIN, 8'h09, 8'hff, 8'h3f},
			'{dmc_pkg::ADDR_AMP1_BLK, 8'h00, 8'hff, 8'h3f},
			'{6'h28, 8'h00, 8'hff, 8'h00}};
		cyc(20);
		resetn = 1'b1;
		chk({thr_ov, thr_p, a1d, a1g, a2d, a2g}, {2'b10, 6'h09}, "reset outputs");
		chk(diag, 16'h0000, "reset diag");
		for (int i = 0; i < 6; i++) begin
			u_dmc_host_model.xfer(1'b0, rows[i].a, 8'h00, q);
			chk(q, rows[i].rst, "reset value");
			u_dmc_host_model.xfer(1'b1, rows[i].a, rows[i].wd, q);
			u_dmc_host_model.xfer(1'b0, rows[i].a, 8'h00, q);
			chk(q, rows[i].exp, "readback");
		end
		chk({thr_ov, thr_p}, 2'b01, "thresholds");
		chk({a1d, a1g, a2d, a2g}, 6'h3f, "amp fields");
		cyc(2);
		chk(diag, 16'h93a5, "diag order");
		gen = 1'b0;
		cyc(4);
		chk(diag, 16'h0000, "diag gated");
		gen = 1'b1;
		// Every overvoltage response code, fastest deglitch
		for (int m = 0; m < 4; m++) begin
			u_dmc_host_model.xfer(1'b1, dmc_pkg::ADDR_VMON, {1'b0, m[1:0], 5'h00}, q);
			sov = 1'b1;
			cyc(40);
			chk({ovf, ovw}, {m < 2, m == 2}, "ov response");
			sov = 1'b0;
			cyc(20);
			chk(ovf, m == 0, "ov after condition gone");
			pulse_clear();
			chk(ovf, 1'b0, "ov cleared");
		end
		// Short glitch ignored while the monitor is live and latching
		u_dmc_host_model.xfer(1'b1, dmc_pkg::ADDR_VMON, 8'h00, q);
		sov = 1'b1;
		cyc(6);
		sov = 1'b0;
		cyc(20);
		chk(ovf, 1'b0, "glitch ignored");
		// Every deglitch code: quiet for the whole time, fault soon after
		for (int g = 0; g < 4; g++) begin
			u_dmc_host_model.xfer(1'b1, dmc_pkg::ADDR_VMON,
				{3'h0, g[1:0], 3'h0}, q);
			sov = 1'b1;
			cyc(dmc_pkg::DG_BASE_CYC << g);
			chk(ovf, 1'b0, "before deglitch");
			cyc(10);
			chk(ovf, 1'b1, "after deglitch");
			sov = 1'b0;
			cyc(8);
			pulse_clear();
		end
		// Undervoltage latched, then auto recovery
		for (int m = 0; m < 2; m++) begin
			u_dmc_host_model.xfer(1'b1, dmc_pkg::ADDR_VMON, m ? 8'h82 : 8'h00, q);
			{suv, puv} = 2'b11;
			cyc(12);
			chk({uvf, pf}, 2'b11, "uv set");
			{suv, puv} = 2'b00;
			cyc(10);
			chk({uvf, pf}, m ? 2'b00 : 2'b11, "uv after gone");
			pulse_clear();
			chk({uvf, pf}, 2'b00, "uv cleared");
		end
		// Every trigger and duration code; the next bridge up must not trigger
		for (int i = 0; i < 8; i++) begin
			d = (i + 3) % 8;
			u_dmc_host_model.xfer(1'b1, dmc_pkg::ADDR_AMP1_BLK, {2'b11, i[2:0], d[2:0]}, q);
			sw[(i + 1) % 8] = ~sw[(i + 1) % 8];
			c = 0;
			repeat (40) begin
				cyc(1);
				c += (blank === 1'b1);
			end
			chk(16'(c), 16'h0, "wrong bridge blanked");
			sw[i] = ~sw[i];
			c = 0;
			repeat (40) begin
				cyc(1);
				c += (blank === 1'b1);
			end
			chk(16'(c), d ? 16'(32'(gdt) * (d + 1) / 8) : 16'h0, "blank length");
		end
		// Reset in mid-run restores every register
		resetn = 1'b0;
		cyc(2);
		resetn = 1'b1;
		chk({thr_ov, thr_p, a1d, a1g, a2d, a2g}, {2'b10, 6'h09},
			"reset again");
		cyc(2);
		chk(diag, 16'h0000, "diag after reset");
		for (int i = 0; i < 5; i++) begin
			u_dmc_host_model.xfer(1'b0, rows[i].a, 8'h00, q);
			chk(q, rows[i].rst, "value after reset");
		end
		conclude();
	end
endmodule

bind dmc_config_regs dmc_config_regs_chk u_dmc_config_regs_chk (.clk, .resetn,
	.req, .req_valid, .rdata, .rvalid, .offline_diag_global_en, .diag_source_en,
	.supply_ov_cmp, .fault_clear, .supply_overvolt_threshold,
	.pump_undervolt_threshold, .supply_ov_fault, .pump_uv_fault,
	.amp1_ref_divider, .amp1_gain, .amp2_ref_divider, .amp2_gain, .amp1_blank);
`default_nettype wire
